//--- pkg/dsf_pkg.sv
// disk sector format and ECC path: shared constants, types and functions
package dsf_pkg;
	localparam int SEC_SYMS = 512;             // data symbols per sector
	localparam int ILV      = 36;              // interleaves, one fix each
	localparam int CHK_SYMS = 72;              // two check symbols per interleave
	localparam int ECC_T    = 36;              // correctable symbols per sector
	localparam int AUTO_MAX = 32;              // on-the-fly correction limit
	localparam int LOG_N    = 8;               // corrected-error log depth
	localparam int PRE_SYMS = 8;               // preamble length in symbols
	localparam logic [9:0] PRE_PAT = 10'h155;  // preamble pattern
	localparam logic [9:0] AM_PAT  = 10'h3C5;  // address mark pattern
	localparam logic [9:0] GF_POLY = 10'h009;  // x^10 + x^3 + 1, low terms
	localparam logic [5:0] LAST_IL = 6'h07;    // interleave of last data symbol
	localparam int CLK_PS     = 5000;          // 200 MHz system clock
	localparam int WR_BIT_PS  = 15000;         // write bit cell
	localparam int WR_BIT_CYC = (WR_BIT_PS / CLK_PS < 1) ? 1 : WR_BIT_PS / CLK_PS;

	typedef logic [9:0] dsf_sym_type;          // permuted code symbol

	typedef enum logic [3:0] {
		ST_IDLE  = 4'h0, ST_HUNT = 4'h1, ST_IDCHK = 4'h3, ST_RDATA = 4'h2,
		ST_RCHK  = 4'h6, ST_FIX  = 4'h7, ST_DELV  = 4'h5, ST_FIN   = 4'h4,
		ST_WDATA = 4'hC, ST_WCHK = 4'hD
	} dsf_state_type;

	typedef struct packed {
		logic        ref_clk;                  // read reference clock
		dsf_sym_type sym;                      // decoded read symbol
		logic        erase;                    // erasure pointer for sym
		logic        servo;                    // servo field window
	} dsf_chan_in_type;

	typedef struct packed {
		logic rd_gate;
		logic wr_gate;
		logic wr_bit;                          // serial write data
		logic servo_agc;                       // servo AGC gate
	} dsf_chan_out_type;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} dsf_byte_type;

	typedef struct packed {
		dsf_sym_type id;                       // sector identity
		logic [5:0]  errs;                     // erroneous symbols seen
		logic        uncorr;                   // left uncorrected
	} dsf_log_type;

	// multiply by the field generator
	function automatic dsf_sym_type gf_mul_a(input dsf_sym_type v);
		return {v[8:0], 1'b0} ^ (v[9] ? GF_POLY : 10'h000);
	endfunction : gf_mul_a

	// run-length limiting byte to symbol map
	function automatic dsf_sym_type rll_enc(input logic [7:0] b);
		return {b[7:4], ~b[4], b[3:0], ~b[0]};
	endfunction : rll_enc

	function automatic logic [7:0] rll_dec(input dsf_sym_type s);
		return {s[9:6], s[4:1]};
	endfunction : rll_dec
endpackage : dsf_pkg

//--- core/dsf_wr_ser.sv
// write serialiser: preamble, address mark, then symbols as a bit stream
`timescale 1ns/1ps
`default_nettype none
module dsf_wr_ser (
	input  wire logic                 sys_clk_i,
	input  wire logic                 rst_i,
	input  wire logic                 start_i,   // begin a frame
	input  wire dsf_pkg::dsf_sym_type sym_i,     // next payload symbol
	input  wire logic                 valid_i,
	input  wire logic                 last_i,    // sym_i ends the frame
	output logic                      ready_o,
	output logic                      bit_o,
	output logic                      busy_o
);
	import dsf_pkg::*;

	typedef enum logic [1:0] {PH_IDLE = 2'h0, PH_PRE = 2'h1, PH_DATA = 2'h3,
		PH_TAIL = 2'h2} dsf_ph_type;

	typedef struct packed {
		dsf_ph_type  ph;
		dsf_sym_type sh;                         // shift register, msb first
		logic [3:0]  nb;                         // bits left in sh
		logic [3:0]  pc;                         // preamble symbols loaded
		logic [3:0]  div;                        // bit cell divider
		logic        last;                       // final symbol loaded
		logic        bit_q;
	} dsf_ser_type;

	dsf_ser_type q, d;
	logic        tick;                           // end of a bit cell

	assign tick    = (q.div == 4'(WR_BIT_CYC - 1));
	assign ready_o = (q.ph == PH_DATA) && (q.nb == 4'h0) && !q.last;
	assign bit_o   = q.bit_q;
	assign busy_o  = (q.ph != PH_IDLE);

	// frame sequencing and shifting
	always_comb begin
		d = q;
		d.div = tick ? 4'h0 : q.div + 4'h1;
		if (tick && q.nb != 4'h0) begin
			d.bit_q = q.sh[9];
			d.sh    = {q.sh[8:0], 1'b0};
			d.nb    = q.nb - 4'h1;
		end
		case (q.ph)
			PH_IDLE: begin
				d.div = 4'h0;
				if (start_i) begin
					d.ph   = PH_PRE;
					d.sh   = PRE_PAT;
					d.nb   = 4'hA;
					d.pc   = 4'h1;
					d.last = 1'b0;
				end
			end
			PH_PRE: begin
				if (q.nb == 4'h0) begin
					d.nb = 4'hA;
					if (q.pc < 4'(PRE_SYMS)) begin
						d.sh = PRE_PAT;
						d.pc = q.pc + 4'h1;
					end else begin
						d.sh = AM_PAT;
						d.ph = PH_DATA;
					end
				end
			end
			PH_DATA: begin
				if (q.nb == 4'h0 && q.last) begin
					d.ph = PH_TAIL;                 // hold the final bit one cell
				end else if (q.nb == 4'h0 && valid_i) begin
					d.sh   = sym_i;
					d.nb   = 4'hA;
					d.last = last_i;
				end
			end
			PH_TAIL: if (tick) d.ph = PH_IDLE;
			default: d.ph = PH_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) q <= '0;
		else       q <= d;
	end

	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	pre_first_a: assert property (start_i && !busy_o |=> q.sh == PRE_PAT && q.pc == 4'h1)
		else $error("frame did not open with preamble");
	mark_after_a: assert property ($rose(q.ph == PH_DATA) |-> q.sh == AM_PAT)
		else $error("address mark not loaded before data");
endmodule : dsf_wr_ser
`default_nettype wire

//--- core/dsf_sector_path.sv
// sector format and ECC data path between channel and buffer controller
`timescale 1ns/1ps
`default_nettype none
module dsf_sector_path (
	input  wire logic                      sys_clk_i,
	input  wire logic                      rst_i,
	input  wire logic                      start_i,      // start one sector
	input  wire logic                      cmd_wr_i,     // 1 write, 0 read
	input  wire dsf_pkg::dsf_sym_type      target_i,     // target sector id
	input  wire dsf_pkg::dsf_chan_in_type  chan_i,       // from channel pins
	output dsf_pkg::dsf_chan_out_type      chan_o,       // to channel pins
	input  wire logic                      buf_full_i,   // read buffer full
	output dsf_pkg::dsf_byte_type          buf_o,        // read bytes out
	input  wire dsf_pkg::dsf_byte_type     wbuf_i,       // write bytes in
	output logic                           wr_ready_o,
	input  wire logic                      wbuf_full_i,  // host side full
	output logic                           host_stall_o,
	output logic                           pwr_en_o,     // disk logic power
	output logic                           busy_o,
	output logic                           sec_done_o,
	output logic                           ecc_uncorr_o,
	output logic [5:0]                     ecc_errs_o,
	input  wire logic [2:0]                log_idx_i,
	output dsf_pkg::dsf_log_type           log_o
);
	import dsf_pkg::*;

	typedef struct packed {
		dsf_state_type             st;
		dsf_chan_in_type           sy1, sy2;    // pin synchroniser
		logic                      rprev;       // last sampled ref clock
		logic                      wr;
		dsf_sym_type               tgt;
		logic [9:0]                cnt;         // symbol index
		logic [5:0]                il;          // interleave index
		logic [ILV-1:0][9:0]       s0;          // plain sum syndromes
		logic [ILV-1:0][9:0]       s1;          // weighted syndromes
		logic [ILV-1:0][9:0]       t;           // locator search values
		logic [ILV-1:0]            era_v;
		logic [ILV-1:0][8:0]       era_p;       // erased position
		logic [ILV-1:0]            fixed;
		logic                      auto_ok;
		logic [5:0]                errs;
		logic                      uncorr;
		logic                      hold_v, hold_last, ser_go;
		dsf_sym_type               hold;
		logic [9:0]                fcyc;        // correction cycles used
		logic [2:0]                lptr;
		logic [LOG_N-1:0][16:0]    log;
		dsf_log_type               log_rd;
		dsf_chan_out_type          chan;
		dsf_byte_type              bout;
		logic                      wr_rdy, stall, pwr, done, eflag;
		logic [5:0]                eerr;
	} dsf_core_type;

	dsf_core_type q, d;
	dsf_sym_type  mem [SEC_SYMS];               // sector staging store
	dsf_sym_type  mem_rd, mem_wd;
	logic         mem_we;
	logic         edge_r;                       // ref clock rising
	logic         ser_rdy, ser_bit, ser_busy, cons;

	// count interleaves carrying a nonzero syndrome
	function automatic logic [5:0] bad_cnt(input logic [ILV-1:0] m);
		logic [5:0] n;
		n = 6'h00;
		for (int k = 0; k < ILV; k++) n = n + 6'(m[k]);
		return n;
	endfunction : bad_cnt

	assign edge_r = q.sy2.ref_clk && !q.rprev;
	assign mem_rd = mem[q.cnt[8:0]];
	assign cons   = ser_rdy && q.hold_v;

	dsf_wr_ser u_ser (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.start_i   (q.ser_go),
		.sym_i     (q.hold),
		.valid_i   (q.hold_v),
		.last_i    (q.hold_last),
		.ready_o   (ser_rdy),
		.bit_o     (ser_bit),
		.busy_o    (ser_busy)
	);

	// sequencer, syndromes, correction and delivery
	always_comb begin
		logic [5:0]     k;
		logic           hit;
		logic [ILV-1:0] nzm, bad;
		d = q;
		k = q.il;
		hit = 1'b0;
		nzm = '0;
		bad = '0;
		mem_we = 1'b0;
		mem_wd = q.sy2.sym;
		d.sy1 = chan_i;
		d.sy2 = q.sy1;
		d.rprev = q.sy2.ref_clk;
		d.ser_go = 1'b0;
		d.done = 1'b0;
		d.stall = wbuf_full_i;
		d.log_rd = q.log[log_idx_i];
		if (cons) d.hold_v = 1'b0;
		case (q.st)
			ST_IDLE: begin
				if (start_i) begin
					d.st = ST_HUNT;
					d.pwr = 1'b1;
					d.tgt = target_i;
					d.wr = cmd_wr_i;
					d.s0 = '0;
					d.s1 = '0;
					d.era_v = '0;
					d.fixed = '0;
					d.uncorr = 1'b0;
					d.fcyc = 10'h000;
				end
			end
			ST_HUNT: if (edge_r && q.sy2.sym == AM_PAT) d.st = ST_IDCHK;
			ST_IDCHK: begin
				if (edge_r) begin
					d.cnt = 10'h000;
					d.il = 6'h00;
					if (q.sy2.sym != q.tgt) begin
						d.st = ST_HUNT;
					end else if (q.wr) begin
						d.st = ST_WDATA;
						d.ser_go = 1'b1;
					end else begin
						d.st = ST_RDATA;
					end
				end
			end
			ST_RDATA: begin
				if (edge_r) begin
					mem_we = 1'b1;
					d.s0[k] = q.s0[k] ^ q.sy2.sym;
					d.s1[k] = gf_mul_a(q.s1[k]) ^ q.sy2.sym;
					if (q.sy2.erase) begin
						d.era_v[k] = 1'b1;
						d.era_p[k] = q.cnt[8:0];
					end
					d.il = (k == 6'(ILV - 1)) ? 6'h00 : k + 6'h01;
					d.cnt = q.cnt + 10'h001;
					if (q.cnt == 10'(SEC_SYMS - 1)) begin
						d.st = ST_RCHK;
						d.cnt = 10'h000;
					end
				end
			end
			ST_RCHK: begin
				if (edge_r) begin
					if (q.cnt < 10'(ILV))
						d.s0[q.cnt[5:0]] = q.s0[q.cnt[5:0]] ^ q.sy2.sym;
					else
						d.s1[6'(q.cnt - 10'(ILV))] = q.s1[6'(q.cnt - 10'(ILV))] ^ q.sy2.sym;
					d.cnt = q.cnt + 10'h001;
					if (q.cnt == 10'(CHK_SYMS - 1)) begin
						d.st = ST_FIX;
						d.cnt = 10'(SEC_SYMS - 1);
						d.il = LAST_IL;
					end
				end
			end
			ST_FIX: begin
				// backward search: t grows by the generator per visit
				hit = q.auto_ok && (q.s0[k] != 10'h000) && (q.era_v[k] ?
					(q.era_p[k] == q.cnt[8:0]) : (q.t[k] == q.s1[k]));
				if (hit) begin
					mem_we = 1'b1;
					mem_wd = mem_rd ^ q.s0[k];
					d.fixed[k] = 1'b1;
				end
				d.t[k] = gf_mul_a(q.t[k]);
				d.fcyc = q.fcyc + 10'h001;
				d.il = (k == 6'h00) ? 6'(ILV - 1) : k - 6'h01;
				d.cnt = q.cnt - 10'h001;
				if (q.cnt == 10'h000) begin
					for (int j = 0; j < ILV; j++)
						bad[j] = (q.s0[j] != 10'h000) && ((q.s1[j] != 10'h000) || q.era_v[j]);
					d.uncorr = |(bad & ~d.fixed);
					d.cnt = 10'h000;
					d.st = d.uncorr ? ST_FIN : ST_DELV;
				end
			end
			ST_DELV: begin
				if (!q.bout.valid || !buf_full_i) begin
					if (!q.cnt[9]) begin
						d.bout.valid = 1'b1;
						d.bout.data = rll_dec(mem_rd);
						d.cnt = q.cnt + 10'h001;
					end else begin
						d.bout.valid = 1'b0;
						d.st = ST_FIN;
					end
				end
			end
			ST_WDATA: begin
				if (q.wr_rdy && wbuf_i.valid) begin
					d.hold = rll_enc(wbuf_i.data);
					d.hold_v = 1'b1;
					d.hold_last = 1'b0;
					d.s0[k] = q.s0[k] ^ d.hold;
					d.s1[k] = gf_mul_a(q.s1[k]) ^ d.hold;
					d.il = (k == 6'(ILV - 1)) ? 6'h00 : k + 6'h01;
					d.cnt = q.cnt + 10'h001;
				end else if (q.cnt[9] && !d.hold_v) begin
					d.st = ST_WCHK;
					d.cnt = 10'h000;
				end
			end
			ST_WCHK: begin
				if (!d.hold_v && q.cnt < 10'(CHK_SYMS)) begin
					d.hold = (q.cnt < 10'(ILV)) ? q.s0[q.cnt[5:0]]
						: q.s1[6'(q.cnt - 10'(ILV))];
					d.hold_v = 1'b1;
					d.hold_last = (q.cnt == 10'(CHK_SYMS - 1));
					d.cnt = q.cnt + 10'h001;
				end else if (!q.hold_v && !ser_busy && q.cnt == 10'(CHK_SYMS)) begin
					d.st = ST_FIN;
				end
			end
			ST_FIN: begin
				d.st = ST_IDLE;
				d.pwr = 1'b0;
				d.done = 1'b1;
				if (!q.wr) begin
					d.log[q.lptr] = {q.tgt, q.errs, q.uncorr};
					d.lptr = q.lptr + 3'h1;
					d.eflag = q.uncorr;
					d.eerr = q.errs;
				end
			end
			default: d.st = ST_IDLE;
		endcase
		// settle the error count once the last check symbol is in
		if (q.st == ST_RCHK && d.st == ST_FIX) begin
			for (int j = 0; j < ILV; j++)
				nzm[j] = (d.s0[j] != 10'h000) || (d.s1[j] != 10'h000);
			d.errs = bad_cnt(nzm);
			d.auto_ok = (bad_cnt(nzm) <= 6'(AUTO_MAX));
			d.t = d.s0;
		end
		d.wr_rdy = (d.st == ST_WDATA) && !d.hold_v && !d.cnt[9];
		d.chan.rd_gate = (d.st == ST_HUNT) || (d.st == ST_IDCHK)
			|| (d.st == ST_RDATA) || (d.st == ST_RCHK);
		d.chan.wr_gate = (d.st == ST_WDATA) || (d.st == ST_WCHK);
		d.chan.wr_bit = ser_bit;
		d.chan.servo_agc = q.sy2.servo && !d.chan.wr_gate;
	end

	// state register
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) q <= '0;
		else       q <= d;
	end

	// sector store write port
	always_ff @(posedge sys_clk_i) begin
		if (mem_we) mem[q.cnt[8:0]] <= mem_wd;
	end

	assign chan_o       = q.chan;
	assign buf_o        = q.bout;
	assign wr_ready_o   = q.wr_rdy;
	assign host_stall_o = q.stall;
	assign pwr_en_o     = q.pwr;
	assign busy_o       = q.pwr;
	assign sec_done_o   = q.done;
	assign ecc_uncorr_o = q.eflag;
	assign ecc_errs_o   = q.eerr;
	assign log_o        = q.log_rd;

	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	id_match_a: assert property (q.st == ST_RDATA && $past(q.st) == ST_IDCHK |->
		$past(q.sy2.sym) == q.tgt) else $error("data accepted for wrong sector");
	fix_time_a: assert property (q.fcyc <= 10'(SEC_SYMS))
		else $error("correction overran one sector time");
	full_stall_a: assert property (buf_o.valid && buf_full_i |=> $stable(buf_o))
		else $error("buffer byte changed while full");
	auto_lim_a: assert property (mem_we && q.st == ST_FIX |-> q.errs <= 6'(AUTO_MAX))
		else $error("automatic fix above limit");
	no_bad_data_a: assert property (buf_o.valid |-> !q.uncorr)
		else $error("uncorrectable sector delivered");
	wr_after_id_a: assert property ($rose(chan_o.wr_gate) |-> $past(q.st) == ST_IDCHK
		&& $past(q.sy2.sym, 2) == q.tgt) else $error("write began before target id");
	pwr_on_a: assert property (q.st != ST_IDLE |-> pwr_en_o)
		else $error("sequencer active while powered down");
	log_write_a: assert property (sec_done_o && !q.wr |-> q.log[q.lptr - 3'h1][16:1]
		== {q.tgt, q.eerr}) else $error("sector not logged");
	gate_excl_a: assert property (!(chan_o.rd_gate && chan_o.wr_gate))
		else $error("read and write gate together");
	errs_cap_a: assert property (q.errs <= 6'(ECC_T))
		else $error("error count beyond code size");

	clean_rd_c: cover property (sec_done_o && !q.wr && q.eerr == 6'h00);
	fixed_rd_c: cover property (sec_done_o && !q.wr && q.eerr != 6'h00 && !ecc_uncorr_o);
	uncorr_rd_c: cover property (sec_done_o && ecc_uncorr_o);
	write_c: cover property (sec_done_o && q.wr);
endmodule : dsf_sector_path
`default_nettype wire

//--- sim/dsf_chan_model.sv
// channel model: plays read frames on its reference clock, drives servo window
`timescale 1ns/1ps
`default_nettype none
module dsf_chan_model (
	output dsf_pkg::dsf_chan_in_type chan_o  // to channel pins of the block
);
	import dsf_pkg::*;

	// link clock stands still low outside frames
	initial begin
		chan_o = '0;
	end

	// one symbol and its erasure flag per reference clock period
	task automatic play(input logic [10:0] q[$]);
		foreach (q[i]) begin
			{chan_o.erase, chan_o.sym} = q[i];
			#80 chan_o.ref_clk = 1'b1;
			#80 chan_o.ref_clk = 1'b0;
		end
		// released lines no longer show the last symbol
		{chan_o.erase, chan_o.sym} = ~q[$];
	endtask : play

	// servo field window level, held for eight symbol times
	task automatic servo_win(input logic v);
		chan_o.servo = v;
		#1280;
	endtask : servo_win
endmodule : dsf_chan_model
`default_nettype wire

//--- sim/tb.sv
// self-checking bench for the sector format and ECC path
`timescale 1ns/1ps
`default_nettype none
module tb;
	import dsf_pkg::*;
	logic             sys_clk    = 1'b0;
	logic             rst_i      = 1'b1;
	logic             start_i    = 1'b0;
	logic             cmd_wr_i   = 1'b0;
	dsf_sym_type      target_i   = '0;
	dsf_chan_in_type  chan_i;
	dsf_chan_out_type chan_o;
	logic             buf_full_i = 1'b0;
	dsf_byte_type     buf_o;
	dsf_byte_type     wbuf_i     = '0;
	logic             wbuf_full_i = 1'b0;
	logic             wr_ready_o;
	logic             host_stall_o;
	logic             pwr_en_o;
	logic             busy_o;
	logic             sec_done_o;
	logic             ecc_uncorr_o;
	logic [5:0]       ecc_errs_o;
	logic [2:0]       log_idx_i  = '0;
	dsf_log_type      log_o;
	int               err_count  = 0;
	int               n_compared = 0;
	int               done_cnt   = 0;   // sector end pulses seen
	logic             hs = 1'b0;        // host full at last edge
	logic             r  = 1'b1;        // reset at last edge
	logic [7:0]       wd [512];         // sector bytes
	dsf_sym_type      ck [72];          // expected check symbols
	logic [7:0]       rq [$];           // bytes handed to buffer
	logic [10:0]      fq [$];           // frame for the channel
	logic             bq [$];           // write data per cycle

	dsf_sector_path i_dsf_sector_path (.sys_clk_i(sys_clk), .rst_i(rst_i), .start_i(start_i),
		.cmd_wr_i(cmd_wr_i), .target_i(target_i), .chan_i(chan_i), .chan_o(chan_o),
		.buf_full_i(buf_full_i), .buf_o(buf_o), .wbuf_i(wbuf_i), .wr_ready_o(wr_ready_o),
		.wbuf_full_i(wbuf_full_i), .host_stall_o(host_stall_o), .pwr_en_o(pwr_en_o),
		.busy_o(busy_o), .sec_done_o(sec_done_o), .ecc_uncorr_o(ecc_uncorr_o),
		.ecc_errs_o(ecc_errs_o), .log_idx_i(log_idx_i), .log_o(log_o));
	dsf_chan_model i_dsf_chan_model (.chan_o(chan_i));

	// system clock
	always #2.5 sys_clk = ~sys_clk;

	// buffer side: collect delivered bytes, count sector ends
	always @(posedge sys_clk) begin
		if (buf_o.valid === 1'b1 && !buf_full_i) rq.push_back(buf_o.data);
		if (sec_done_o === 1'b1) done_cnt++;
		hs = wbuf_full_i;
		r  = rst_i;
	end

	// host stall follows host full; random full levels
	always @(negedge sys_clk) begin
		if (!r) check(host_stall_o, hs);
		buf_full_i  <= 1'($urandom % 3 == 0);
		wbuf_full_i <= 1'($urandom % 2);
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check

	task automatic finish_test();
		if (err_count == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : finish_test

	function automatic dsf_sym_type enc(input logic [7:0] b);
		return {b[7:4], ~b[4], b[3:0], ~b[0]};
	endfunction : enc

	function automatic dsf_sym_type mula(input dsf_sym_type v);
		return {v[8:0], 1'b0} ^ (v[9] ? GF_POLY : 10'h000);
	endfunction : mula

	// random sector bytes and their check symbols
	task automatic gen();
		dsf_sym_type s;
		foreach (ck[k]) ck[k] = '0;
		for (int i = 0; i < SEC_SYMS; i++) begin
			wd[i] = 8'($urandom);
			s = enc(wd[i]);
			ck[i % ILV] ^= s;
			ck[ILV + i % ILV] = mula(ck[ILV + i % ILV]) ^ s;
		end
	endtask : gen

	task automatic pre_am(input dsf_sym_type id);
		repeat (PRE_SYMS) fq.push_back({1'b0, PRE_PAT});
		fq.push_back({1'b0, AM_PAT});
		fq.push_back({1'b0, id});
	endtask : pre_am

	task automatic go(input logic w, input dsf_sym_type id);
		@(negedge sys_clk);
		{start_i, cmd_wr_i, target_i} = {1'b1, w, id};
		@(negedge sys_clk);
		start_i = 1'b0;
	endtask : go

	// bounded wait for the sector end pulse
	task automatic wait_done(input int d0);
		for (int n = 0; n < 16000 && done_cnt == d0; n++) @(negedge sys_clk);
		check(done_cnt, d0 + 1);
		@(negedge sys_clk);
		check(pwr_en_o, 0);
	endtask : wait_done

	task automatic lg(input logic [2:0] idx, input dsf_log_type e);
		@(negedge sys_clk);
		log_idx_i = idx;
		repeat (2) @(negedge sys_clk);
		check(log_o, e);
	endtask : lg

	// read: wrong sector first, then target with one error in each of nerr interleaves
	task automatic rd(input dsf_sym_type id, input int nerr);
		int d0;
		int b;
		gen();
		fq.delete();
		rq.delete();
		pre_am(id ^ 10'h001);
		repeat (20) fq.push_back({1'b0, enc(8'($urandom))});
		pre_am(id);
		b = fq.size();
		for (int i = 0; i < SEC_SYMS; i++) fq.push_back({1'b0, enc(wd[i])});
		for (int k = 0; k < 72; k++) fq.push_back({1'b0, ck[k]});
		for (int k = 0; k < nerr; k++) fq[b + k + 36 * (k % 14)] ^= {k[0], 10'($urandom_range(1023, 1))};
		d0 = done_cnt;
		go(1'b0, id);
		go(1'b1, id ^ 10'h002);
		check(pwr_en_o, 1);
		check(busy_o, 1);
		check(chan_o.rd_gate, 1);
		i_dsf_chan_model.servo_win(1'b1);
		check(chan_o.servo_agc, 1);
		i_dsf_chan_model.servo_win(1'b0);
		check(chan_o.servo_agc, 0);
		i_dsf_chan_model.play(fq);
		check(chan_o.wr_gate, 0);
		wait_done(d0);
		check(rq.size(), nerr > AUTO_MAX ? 0 : SEC_SYMS);
		foreach (rq[i]) check(rq[i], wd[i]);
		check(ecc_uncorr_o, nerr > AUTO_MAX);
		check(ecc_errs_o, nerr);
	endtask : rd

	// write bytes held until taken, with random gaps
	task automatic feed();
		bit t;
		t = 1'b1;
		for (int i = 0; i < SEC_SYMS; ) begin
			@(negedge sys_clk);
			if (t || !wbuf_i.valid) wbuf_i = {1'($urandom % 3 != 0), wd[i]};
			@(posedge sys_clk);
			t = wr_ready_o && wbuf_i.valid;
			i += int'(t);
		end
		@(negedge sys_clk);
		wbuf_i.valid = 1'b0;
	endtask : feed

	task automatic wr(input dsf_sym_type id);
		int d0;
		dsf_sym_type s;
		gen();
		fq.delete();
		bq.delete();
		pre_am(id);
		d0 = done_cnt;
		go(1'b1, id);
		fork
			i_dsf_chan_model.play(fq);
			feed();
			begin
				for (int n = 0; n < 20000 && chan_o.wr_gate !== 1'b1; n++) @(negedge sys_clk);
				check(chan_o.rd_gate, 0);
				while (chan_o.wr_gate === 1'b1) begin
					bq.push_back(chan_o.wr_bit);
					@(negedge sys_clk);
				end
			end
		join
		wait_done(d0);
		check(bq.size() >= 30 * 593, 1);
		// bit b shows on the pin for samples 3b+5 to 3b+7 after the gate rises: take the middle
		for (int j = 0; j < 593 && 30 * j + 33 < bq.size(); j++) begin
			for (int k = 0; k < 10; k++) s[9 - k] = bq[30 * j + 3 * k + 6];
			check(s, j < PRE_SYMS ? PRE_PAT : j == PRE_SYMS ? AM_PAT :
				j < 521 ? enc(wd[j - 9]) : ck[j - 521]);
		end
	endtask : wr

	// main sequence
	initial begin
		void'($urandom(32'h9EF9));
		repeat (3) @(negedge sys_clk);
		rst_i = 1'b0;
		check(pwr_en_o, 0);
		lg(3'h5, '0);
		rd(10'h2A7, 32);
		lg(3'h0, {10'h2A7, 6'h20, 1'b0});
		rd(10'h0B3, 33);
		lg(3'h1, {10'h0B3, 6'h21, 1'b1});
		wr(10'h31C);
		finish_test();
	end

	// watchdog: two reads and a write take about 320 us, stay under 100k cycles
	initial begin
		#480000;
		err_count++;
		finish_test();
	end
endmodule : tb
`default_nettype wire
